// ==== hw/serial_unit_pkg.sv ====
package serial_unit_pkg;
    localparam logic [7:0] ADDR_RATE_MODE      = 8'h10;
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h11;
    localparam logic [7:0] ADDR_RX_BUFFER      = 8'h12;
    localparam logic [7:0] ADDR_TX_BUFFER      = 8'h13;

    localparam logic [7:0] CONTROL_STATUS_RESET = 8'h20;
    localparam logic [3:0] RATE_MODE_RESET      = 4'h0;
    localparam logic [7:0] WRITE_MASK           = 8'h1F;

    localparam int BIT_WAKE      = 0;
    localparam int BIT_TX_EN     = 1;
    localparam int BIT_TX_IRQ_EN = 2;
    localparam int BIT_RX_EN     = 3;
    localparam int BIT_RX_IRQ_EN = 4;
    localparam int BIT_TX_EMPTY  = 5;
    localparam int BIT_OVR_FRM   = 6;
    localparam int BIT_RX_FULL   = 7;

    localparam int IDLE_BITS     = 10;
    localparam int OVERSAMPLE    = 8;
    localparam int FRAME_BITS    = 10;

    // Bus clock periods per oversample tick for each internal rate
    localparam int RATE_DIV0 = 2;
    localparam int RATE_DIV1 = 16;
    localparam int RATE_DIV2 = 128;
    localparam int RATE_DIV3 = 512;

    typedef enum logic [1:0] {
        CLK_SRC_OFF  = 2'b00,
        CLK_SRC_INT  = 2'b01,
        CLK_SRC_OUT  = 2'b10,
        CLK_SRC_EXT  = 2'b11
    } clock_source_field_t;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_START = 2'b01,
        RX_DATA  = 2'b11,
        RX_STOP  = 2'b10
    } rx_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       data;
        logic       clk;
        logic       clk_oe;
    } pin_out_t;
endpackage : serial_unit_pkg

// ==== hw/serial_tick_gen.sv ====
module serial_tick_gen
    import serial_unit_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [1:0] rate_sel,
    input  wire logic       ext_sel,
    input  wire logic       ext_clk_in,
    output logic            tick,
    output logic            clk_out
);
    logic [9:0] count;
    logic [9:0] limit;
    logic [2:0] phase;
    logic       ext_prev;

    always_comb begin
        case (rate_sel)
            2'd0:    limit = 10'(RATE_DIV0 - 1);
            2'd1:    limit = 10'(RATE_DIV1 - 1);
            2'd2:    limit = 10'(RATE_DIV2 - 1);
            default: limit = 10'(RATE_DIV3 - 1);
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            count    <= 10'h000;
            ext_prev <= 1'b0;
            tick     <= 1'b0;
        end else begin
            ext_prev <= ext_clk_in;
            if (ext_sel) begin
                count <= 10'h000;
                tick  <= ext_clk_in && !ext_prev;
            end else if (count >= limit) begin
                count <= 10'h000;
                tick  <= 1'b1;
            end else begin
                count <= count + 10'h001;
                tick  <= 1'b0;
            end
        end
    end

    // Bit-rate clock for the pin: one period per eight ticks
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase   <= 3'h0;
            clk_out <= 1'b0;
        end else if (tick) begin
            phase   <= phase + 3'h1;
            clk_out <= (phase >= 3'h3) && (phase != 3'h7);
        end
    end
endmodule : serial_tick_gen

// ==== hw/async_serial_port_with_wakeup.sv ====
// Overview of operation
// - Transmitter and receiver run independently, sharing one format and rate.
// - NRZ mark/space format; clock source internal or external.
// - Bit rate: one of four bus-clock rates or external clock over eight.
// - Receive on port 2 line 3, transmit on line 4, clock on line 2.
// - Line 2 claimed only for clock-out or clock-in source options.
// - All control/status bits readable; writes reach bits 0 to 4 only.
// - Reset loads control/status with 20 hex, only transmit-empty set.
// - Wake flag set by software, cleared after ten consecutive mark bits.
// - While wake flag set, frames discarded; no full or error flags.
// - Transmit enable forces line 4 direction output; stays set afterward.
// - After transmit enable, send ten mark bits before data frames.
// - Transmit enable clear: transmitter off, no influence on line 4.
// - Transmit irq enable gates transmit-empty onto shared request.
// - Receive enable makes line 3 the input regardless of direction.
// - Receive irq enable gates full or overrun/framing onto request.
// - 4-bit write-only rate/mode, read-only rx, write-only tx registers.
// - Registers at 10, 11, 12, 13 hex.
// - Frame: zero start, eight data bits LSB first, one stop.
// - Sample bit centres; zero stop or overrun sets overrun/framing.
// - Full and error flags clear by status read then data read.
//
// Our own choice: the strobed register port.
module async_serial_port_with_wakeup
    import serial_unit_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       port2_line3_in,
    input  wire logic       port2_line2_in,
    output logic            port2_line4_out,
    output logic            port2_line4_claim,
    output logic            port2_line4_dir_set,
    output logic            port2_line2_out,
    output logic            port2_line2_oe,
    output logic            port2_line2_claim,
    output logic            peripheral_irq_request
);
    reg_req_t            req;
    logic [3:0]          rate_mode_control;
    clock_source_field_t clock_source_field;
    logic                wake_flag;
    logic                tx_enable_bit;
    logic                tx_irq_enable;
    logic                rx_enable_bit;
    logic                rx_irq_enable;
    logic                tx_empty_flag;
    logic                rx_full_flag;
    logic                overrun_framing_flag;
    logic [7:0]          serial_control_status;
    logic [7:0]          serial_tx_buffer;
    logic [7:0]          serial_rx_buffer;
    logic                tick;
    logic                bit_clk;
    logic                status_seen;

    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
    assign clock_source_field = clock_source_field_t'(rate_mode_control[3:2]);
    assign serial_control_status = {rx_full_flag, overrun_framing_flag,
                                    tx_empty_flag, rx_irq_enable,
                                    rx_enable_bit, tx_irq_enable,
                                    tx_enable_bit, wake_flag};

    serial_tick_gen u_tick (
        .core_clk   (core_clk),
        .rstn       (rstn),
        .rate_sel   (rate_mode_control[1:0]),
        .ext_sel    (clock_source_field == CLK_SRC_EXT),
        .ext_clk_in (port2_line2_in),
        .tick       (tick),
        .clk_out    (bit_clk)
    );

    // Transmitter
    logic [2:0] tx_sub;
    logic [3:0] tx_bits;
    logic [9:0] tx_shift;
    logic       tx_busy;
    logic       tx_ready;
    logic       tx_load;
    logic       tx_bit_end;

    assign tx_bit_end = tick && (tx_sub == 3'(OVERSAMPLE - 1));
    assign tx_load = tx_bit_end && tx_ready && !tx_busy && !tx_empty_flag;

    always_ff @(posedge core_clk) begin
        if (!rstn || !tx_enable_bit) begin
            tx_sub   <= 3'h0;
            tx_bits  <= 4'(IDLE_BITS);
            tx_shift <= 10'h3FF;
            tx_busy  <= 1'b0;
            tx_ready <= 1'b0;
        end else if (tick) begin
            tx_sub <= tx_sub + 3'h1;
            if (tx_bit_end) begin
                if (!tx_ready) begin
                    tx_bits <= tx_bits - 4'h1;
                    if (tx_bits == 4'h1)
                        tx_ready <= 1'b1;
                end else if (tx_load) begin
                    tx_shift <= {1'b1, serial_tx_buffer, 1'b0};
                    tx_bits  <= 4'(FRAME_BITS - 1);
                    tx_busy  <= 1'b1;
                end else if (tx_busy) begin
                    tx_shift <= {1'b1, tx_shift[9:1]};
                    tx_bits  <= tx_bits - 4'h1;
                    if (tx_bits == 4'h0)
                        tx_busy <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            port2_line4_out   <= 1'b1;
            port2_line4_claim <= 1'b0;
        end else begin
            port2_line4_claim <= tx_enable_bit;
            port2_line4_out   <= tx_busy ? tx_shift[0] : 1'b1;
        end
    end

    // Sticky direction: never cleared by software through this block
    always_ff @(posedge core_clk) begin
        if (!rstn)
            port2_line4_dir_set <= 1'b0;
        else if (tx_enable_bit)
            port2_line4_dir_set <= 1'b1;
    end

    // Receiver
    rx_state_t  rx_state;
    logic [2:0] rx_sub;
    logic [2:0] rx_count;
    logic [7:0] rx_shift;
    logic [3:0] mark_run;
    logic       rx_in;
    logic       rx_done;
    logic       rx_stop_ok;
    logic       rx_centre;

    assign rx_in = port2_line3_in;
    assign rx_centre = tick && (rx_sub == 3'(OVERSAMPLE / 2 - 1));

    always_ff @(posedge core_clk) begin
        if (!rstn || !rx_enable_bit) begin
            rx_state   <= RX_IDLE;
            rx_sub     <= 3'h0;
            rx_count   <= 3'h0;
            rx_shift   <= 8'h00;
            rx_done    <= 1'b0;
            rx_stop_ok <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (tick) begin
                rx_sub <= rx_sub + 3'h1;
                case (rx_state)
                    RX_IDLE: begin
                        rx_sub <= 3'h0;
                        if (!rx_in)
                            rx_state <= RX_START;
                    end
                    RX_START: begin
                        if (rx_centre)
                            rx_state <= rx_in ? RX_IDLE : RX_DATA;
                    end
                    RX_DATA: begin
                        if (rx_centre) begin
                            rx_shift <= {rx_in, rx_shift[7:1]};
                            rx_count <= rx_count + 3'h1;
                            if (rx_count == 3'h7)
                                rx_state <= RX_STOP;
                        end
                    end
                    RX_STOP: begin
                        if (rx_centre) begin
                            rx_done    <= 1'b1;
                            rx_stop_ok <= rx_in;
                            rx_state   <= RX_IDLE;
                        end
                    end
                    default: rx_state <= RX_IDLE;
                endcase
            end
        end
    end

    // Idle-line detector counts a mark bit time after each run of eight mark ticks
    logic [2:0] idle_sub;
    logic       idle_seen;
    always_ff @(posedge core_clk) begin
        if (!rstn || !rx_enable_bit) begin
            idle_sub  <= 3'h0;
            mark_run  <= 4'h0;
            idle_seen <= 1'b0;
        end else begin
            idle_seen <= 1'b0;
            if (tick) begin
                idle_sub <= idle_sub + 3'h1;
                if (!rx_in) begin
                    mark_run <= 4'h0;
                    idle_sub <= 3'h0;
                end else if (idle_sub == 3'(OVERSAMPLE - 1)) begin
                    if (mark_run == 4'(IDLE_BITS - 1)) begin
                        idle_seen <= 1'b1;
                        mark_run  <= 4'h0;
                    end else
                        mark_run <= mark_run + 4'h1;
                end
            end
        end
    end

    // Registers
    logic wr_rate, wr_ctrl, wr_tx, rd_ctrl, rd_rx, clr_rx;
    assign wr_rate = req.wr && req.addr == ADDR_RATE_MODE;
    assign wr_ctrl = req.wr && req.addr == ADDR_CONTROL_STATUS;
    assign wr_tx   = req.wr && req.addr == ADDR_TX_BUFFER;
    assign rd_ctrl = req.rd && req.addr == ADDR_CONTROL_STATUS;
    assign rd_rx   = req.rd && req.addr == ADDR_RX_BUFFER;
    assign clr_rx  = rd_rx && status_seen;

    always_ff @(posedge core_clk) begin
        if (!rstn)
            rate_mode_control <= RATE_MODE_RESET;
        else if (wr_rate)
            rate_mode_control <= req.wdata[3:0];
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            {rx_irq_enable, rx_enable_bit, tx_irq_enable, tx_enable_bit}
                <= CONTROL_STATUS_RESET[4:1];
            wake_flag <= CONTROL_STATUS_RESET[BIT_WAKE];
        end else begin
            if (wr_ctrl) begin
                tx_enable_bit <= req.wdata[BIT_TX_EN];
                tx_irq_enable <= req.wdata[BIT_TX_IRQ_EN];
                rx_enable_bit <= req.wdata[BIT_RX_EN];
                rx_irq_enable <= req.wdata[BIT_RX_IRQ_EN];
            end
            // Software may only set the wake flag; hardware clears it
            if (idle_seen)
                wake_flag <= 1'b0;
            else if (wr_ctrl && req.wdata[BIT_WAKE])
                wake_flag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            tx_empty_flag    <= CONTROL_STATUS_RESET[BIT_TX_EMPTY];
            serial_tx_buffer <= 8'h00;
        end else begin
            if (wr_tx)
                serial_tx_buffer <= req.wdata;
            // A write in the load cycle holds the flag clear for new data
            if (wr_tx)
                tx_empty_flag <= 1'b0;
            else if (tx_load)
                tx_empty_flag <= 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rx_full_flag         <= CONTROL_STATUS_RESET[BIT_RX_FULL];
            overrun_framing_flag <= CONTROL_STATUS_RESET[BIT_OVR_FRM];
            serial_rx_buffer     <= 8'h00;
            status_seen          <= 1'b0;
        end else begin
            if (rd_ctrl)
                status_seen <= rx_full_flag || overrun_framing_flag;
            else if (rd_rx)
                status_seen <= 1'b0;
            // Set wins over the read-sequence clear
            if (rx_done && !wake_flag) begin
                if (!rx_stop_ok || rx_full_flag)
                    overrun_framing_flag <= 1'b1;
                else if (clr_rx)
                    overrun_framing_flag <= 1'b0;
                if (rx_stop_ok && !rx_full_flag) begin
                    rx_full_flag     <= 1'b1;
                    serial_rx_buffer <= rx_shift;
                end else if (clr_rx)
                    rx_full_flag <= 1'b0;
            end else if (clr_rx) begin
                rx_full_flag         <= 1'b0;
                overrun_framing_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (rd_ctrl)
            reg_rdata <= serial_control_status;
        else if (rd_rx)
            reg_rdata <= serial_rx_buffer;
        else
            reg_rdata <= 8'h00;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            port2_line2_out   <= 1'b0;
            port2_line2_oe    <= 1'b0;
            port2_line2_claim <= 1'b0;
        end else begin
            port2_line2_out   <= bit_clk;
            port2_line2_oe    <= clock_source_field == CLK_SRC_OUT;
            port2_line2_claim <= clock_source_field == CLK_SRC_OUT
                              || clock_source_field == CLK_SRC_EXT;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn)
            peripheral_irq_request <= 1'b0;
        else
            peripheral_irq_request <= (tx_irq_enable && tx_empty_flag)
                || (rx_irq_enable
                    && (rx_full_flag || overrun_framing_flag));
    end
endmodule : async_serial_port_with_wakeup

// ==== dv/serial_unit_sva.sv ====
module serial_unit_sva
    import serial_unit_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       port2_line4_out,
    input  wire logic       port2_line4_claim,
    input  wire logic       port2_line4_dir_set,
    input  wire logic       port2_line2_oe,
    input  wire logic       port2_line2_claim,
    input  wire logic       peripheral_irq_request
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // Any rate gives at least 16 bus cycles a bit, so 150 is safe
    logic [7:0] on_cycles;

    always_ff @(posedge core_clk) begin
        if (!rstn || !port2_line4_claim) begin
            on_cycles <= 8'h00;
        end else if (on_cycles != 8'hFF) begin
            on_cycles <= on_cycles + 8'h01;
        end
    end

    sequence s_status_wr;
        reg_wr && reg_addr == ADDR_CONTROL_STATUS;
    endsequence
    sequence s_rate_wr;
        reg_wr && reg_addr == ADDR_RATE_MODE;
    endsequence
    sequence s_tx_off;
        !port2_line4_claim [*2];
    endsequence

    a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    a_wo_reads_zero: assert property (reg_rd && (reg_addr == ADDR_RATE_MODE
        || reg_addr == ADDR_TX_BUFFER) |=> reg_rdata == 8'h00)
        else $error("write-only register read back nonzero");
    a_unmapped_zero: assert property (reg_rd && (reg_addr < ADDR_RATE_MODE
        || reg_addr > ADDR_TX_BUFFER) |=> reg_rdata == 8'h00)
        else $error("unmapped address read back nonzero");
    a_tx_claim_on: assert property (s_status_wr ##0 reg_wdata[BIT_TX_EN]
        |-> ##[1:2] port2_line4_claim)
        else $error("transmit line not claimed after enable");
    a_tx_claim_off: assert property (s_status_wr ##0 !reg_wdata[BIT_TX_EN]
        |-> ##[1:2] !port2_line4_claim)
        else $error("transmit line still claimed after disable");
    a_tx_off_mark: assert property (s_tx_off |-> port2_line4_out)
        else $error("disabled transmitter drives space");
    a_dir_sticky: assert property (port2_line4_dir_set |=> port2_line4_dir_set)
        else $error("direction request dropped");
    a_dir_with_tx: assert property ($rose(port2_line4_claim)
        |-> ##[0:1] port2_line4_dir_set)
        else $error("direction request missing after enable");
    a_preamble_mark: assert property (port2_line4_claim && on_cycles < 8'h96
        |-> port2_line4_out)
        else $error("space sent inside preamble");
    a_irq_masked: assert property (s_status_wr ##0 !reg_wdata[BIT_TX_IRQ_EN]
        && !reg_wdata[BIT_RX_IRQ_EN] |-> ##2 !peripheral_irq_request)
        else $error("interrupt raised while masked");
    a_line2_drive: assert property (s_rate_wr ##0 reg_wdata[3:2] == 2'h2
        |-> ##[1:2] (port2_line2_oe && port2_line2_claim))
        else $error("clock output not driven");
    a_line2_free: assert property (s_rate_wr ##0 !reg_wdata[3]
        |-> ##[1:2] !port2_line2_claim)
        else $error("clock line claimed for internal source");
endmodule : serial_unit_sva

bind async_serial_port_with_wakeup serial_unit_sva u_sva (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .port2_line4_out(port2_line4_out),
    .port2_line4_claim(port2_line4_claim),
    .port2_line4_dir_set(port2_line4_dir_set),
    .port2_line2_oe(port2_line2_oe), .port2_line2_claim(port2_line2_claim),
    .peripheral_irq_request(peripheral_irq_request)
);

// ==== dv/serial_peer.sv ====
module serial_peer
    import serial_unit_pkg::*;
#(
    parameter int BIT_CYCLES = 16
)
(
    input  wire logic core_clk,
    input  wire logic line_in,
    output logic      line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_byte;
    logic       got_stop;
    int         got_count;
    int         start_cycle;
    int         cycle;

    initial begin
        line_out = 1'b1;
        got_count = 0;
        cycle = 0;
    end

    always @(posedge core_clk) begin
        cycle <= cycle + 1;
    end

    // Same bit time both ways, as the device shares one rate
    task automatic send_frame(input logic [7:0] data, input logic stop);
        logic [9:0] bits;
        bits = {stop, data, 1'b0};
        for (int i = 0; i < FRAME_BITS; i++) begin
            line_out <= bits[i];
            repeat (BIT_CYCLES) @(posedge core_clk);
        end
        line_out <= 1'b1;
        // One mark bit apart: far too short to count as an idle gap
        repeat (BIT_CYCLES) @(posedge core_clk);
    endtask : send_frame

    initial begin : capture
        logic [9:0] sh;
        forever begin
            @(negedge line_in);
            start_cycle = cycle;
            repeat (BIT_CYCLES / 2) @(posedge core_clk);
            for (int i = 0; i < FRAME_BITS; i++) begin
                sh[i] = line_in;
                if (i < FRAME_BITS - 1) begin
                    repeat (BIT_CYCLES) @(posedge core_clk);
                end
            end
            got_byte = sh[8:1];
            got_stop = sh[9];
            got_count++;
        end
    end
endmodule : serial_peer

// ==== dv/test_async_serial_port_with_wakeup.sv ====
module test_async_serial_port_with_wakeup
    import serial_unit_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 16;
    logic       core_clk;
    logic       rstn;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       line3;
    logic       line4;
    logic       line4_claim;
    logic       line4_dir;
    logic       line2_oe;
    logic       line2_claim;
    logic       line2_in;
    logic       line2_out;
    logic       irq;
    logic [7:0] s;
    int         miscompares;
    int         compares;
    int         t0;
    int         highs;

    async_serial_port_with_wakeup DUT (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .port2_line3_in(line3),
        .port2_line2_in(line2_in), .port2_line4_out(line4),
        .port2_line4_claim(line4_claim), .port2_line4_dir_set(line4_dir),
        .port2_line2_out(line2_out), .port2_line2_oe(line2_oe),
        .port2_line2_claim(line2_claim), .peripheral_irq_request(irq));

    serial_peer #(.BIT_CYCLES(BIT)) peer (
        .core_clk(core_clk), .line_in(line4), .line_out(line3));

    // Runs at half the bus clock, the fastest allowed
    always @(posedge core_clk) begin
        line2_in <= rstn && !line2_in;
    end

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge core_clk);
    endtask : reg_read

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_read(a, s);
        check(s, exp);
    endtask : rd_chk

    task automatic give_up();
        miscompares++;
        $display("wrong value at %0t: wait ran out", $time);
        print_verdict();
    endtask : give_up

    task automatic wait_rx(input int n);
        int k;
        for (k = 0; k < 4000 && peer.got_count < n; k++) begin
            @(posedge core_clk);
        end
        if (k == 4000) begin
            give_up();
        end
    endtask : wait_rx

    // Status polling arms the receive clear, so only used with flags clear
    task automatic wait_flag(input int pos, input logic v);
        int k;
        for (k = 0; k < 400; k++) begin
            reg_read(ADDR_CONTROL_STATUS, s);
            if (s[pos] === v) break;
        end
        if (k == 400) begin
            give_up();
        end
    endtask : wait_flag

    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        logic [3:0] modes [4];
        logic [1:0] lines [4];
        modes = '{4'h0, 4'h4, 4'h8, 4'hC};
        lines = '{2'h0, 2'h0, 2'h3, 2'h2};
        miscompares = 0;
        compares = 0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        rd_chk(ADDR_CONTROL_STATUS, 8'h20);
        reg_write(ADDR_CONTROL_STATUS, 8'hC0);
        rd_chk(ADDR_CONTROL_STATUS, 8'h20);
        rd_chk(ADDR_RATE_MODE, 8'h00);
        rd_chk(ADDR_TX_BUFFER, 8'h00);
        rd_chk(8'h15, 8'h00);
        reg_write(ADDR_RATE_MODE, 8'h04);
        reg_write(ADDR_CONTROL_STATUS, 8'h06);
        t0 = peer.cycle;
        reg_write(ADDR_TX_BUFFER, 8'h3C);
        rd_chk(ADDR_CONTROL_STATUS, 8'h06);
        check({7'h00, irq}, 8'h00);
        check({7'h00, line4_dir}, 8'h01);
        wait_rx(1);
        check(peer.got_byte, 8'h3C);
        check({7'h00, peer.got_stop}, 8'h01);
        check(8'(peer.start_cycle - t0 >= BIT * IDLE_BITS - 2), 8'h01);
        rd_chk(ADDR_CONTROL_STATUS, 8'h26);
        check({7'h00, irq}, 8'h01);
        reg_write(ADDR_TX_BUFFER, 8'h81);
        wait_flag(BIT_TX_EMPTY, 1'b1);
        reg_write(ADDR_TX_BUFFER, 8'h7E);
        wait_rx(2);
        check(peer.got_byte, 8'h81);
        wait_rx(3);
        check(peer.got_byte, 8'h7E);
        reg_write(ADDR_CONTROL_STATUS, 8'h00);
        @(posedge core_clk);
        check({6'h00, line4_claim, line4}, 8'h01);
        check({7'h00, line4_dir}, 8'h01);
        reg_write(ADDR_CONTROL_STATUS, 8'h18);
        peer.send_frame(8'hA5, 1'b1);
        rd_chk(ADDR_RX_BUFFER, 8'hA5);
        rd_chk(ADDR_CONTROL_STATUS, 8'hB8);
        check({7'h00, irq}, 8'h01);
        rd_chk(ADDR_RX_BUFFER, 8'hA5);
        rd_chk(ADDR_CONTROL_STATUS, 8'h38);
        check({7'h00, irq}, 8'h00);
        peer.send_frame(8'hA1, 1'b1);
        peer.send_frame(8'h5A, 1'b1);
        rd_chk(ADDR_CONTROL_STATUS, 8'hF8);
        rd_chk(ADDR_RX_BUFFER, 8'hA1);
        rd_chk(ADDR_CONTROL_STATUS, 8'h38);
        fork
            peer.send_frame(8'h00, 1'b1);
            begin
                repeat (20) @(posedge core_clk);
                reg_write(ADDR_CONTROL_STATUS, 8'h19);
            end
        join
        rd_chk(ADDR_CONTROL_STATUS, 8'h39);
        wait_flag(BIT_WAKE, 1'b0);
        rd_chk(ADDR_CONTROL_STATUS, 8'h38);
        // Runs before the mode loop: a zero stop bit may start a stray frame afterwards
        peer.send_frame(8'h55, 1'b0);
        rd_chk(ADDR_CONTROL_STATUS, 8'h78);
        for (int i = 0; i < 4; i++) begin
            reg_write(ADDR_RATE_MODE, {4'h0, modes[i]});
            @(posedge core_clk);
            check({6'h00, line2_claim, line2_oe}, {6'h00, lines[i]});
            // Same rate as the mode before, so no phase jump here
            if (i == 2) begin
                highs = 0;
                repeat (BIT) begin
                    @(posedge core_clk);
                    highs += line2_out;
                end
                check(8'(highs), 8'(BIT / 2));
            end
        end
        peer.send_frame(8'hC3, 1'b1);
        rd_chk(ADDR_RX_BUFFER, 8'hC3);
        print_verdict();
    end
endmodule : test_async_serial_port_with_wakeup
